/* File: hvip_pkg.sv */
// Constants, codes and carrier types for the high-voltage indirect register port
package hvip_pkg;

    // Register byte addresses on the APB side
    localparam logic [31:0] HVIP_CMD_ADDR = 32'hFFFF0804;
    localparam logic [31:0] HVIP_DATA_ADDR = 32'hFFFF080C;

    // Reset values
    localparam logic [7:0] HVIP_CMD_RESET = 8'h00;
    localparam logic [11:0] HVIP_DATA_RESET = 12'h000;

    // Command bytes
    localparam logic [7:0] HVIP_RD_CFG_FIRST = 8'h00;
    localparam logic [7:0] HVIP_RD_CFG_SECOND = 8'h01;
    localparam logic [7:0] HVIP_RD_STATUS = 8'h02;
    localparam logic [7:0] HVIP_RD_MONITOR = 8'h03;
    localparam logic [7:0] HVIP_WR_CFG_FIRST = 8'h08;
    localparam logic [7:0] HVIP_WR_CFG_SECOND = 8'h09;

    // Field positions in the command port read view and the data port
    localparam int HVIP_BUSY_BIT = 0;
    localparam int HVIP_RXOK_BIT = 1;
    localparam int HVIP_TXOK_BIT = 2;
    localparam int HVIP_WRITE_CMD_BIT = 3;

    // Link timing: serial clock is the link clock divided by two
    localparam int HVIP_SCLK_KHZ = 2560;
    localparam int HVIP_LINK_CLK_KHZ = HVIP_SCLK_KHZ * 2;
    localparam int HVIP_PCLK_MHZ = 50;
    localparam int HVIP_LATENCY_US = 10;
    localparam int HVIP_LATENCY_CYC = HVIP_LATENCY_US * HVIP_PCLK_MHZ;

    // Frame shape: 12 bits out, turnaround, ack, then 8 data bits plus odd parity
    localparam logic [3:0] HVIP_FRAME_LAST = 4'hB;
    localparam logic [3:0] HVIP_RESP_LAST = 4'h8;

    // Link sequencer states
    typedef enum logic [2:0] {
        HVIP_IDLE = 3'b000,
        HVIP_SEND = 3'b001,
        HVIP_TURN = 3'b010,
        HVIP_ACK = 3'b011,
        HVIP_RECV = 3'b100,
        HVIP_DONE = 3'b101
    } hvip_state_t;

    // Word sent to the high-voltage side
    typedef struct packed {
        logic [3:0] tag;
        logic [7:0] val;
    } hvip_frame_t;

    // Outcome returned by the link
    typedef struct packed {
        logic ack;
        logic rd_ok;
        logic [7:0] rd_val;
    } hvip_result_t;

endpackage

/* File: hvip_port.sv */
// APB command/data port with serial link to the high-voltage register set
`timescale 1ns/1ps
`default_nettype none

module hvip_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hv_link_clk,
    input wire logic hv_sdata_in,
    output logic hv_sclk,
    output logic hv_sdata_out,
    output logic hv_sdata_oe
);

    // Only the six documented codes launch a transfer
    function automatic logic cmd_valid(input logic [7:0] c);
        cmd_valid = (c == hvip_pkg::HVIP_RD_CFG_FIRST) || (c == hvip_pkg::HVIP_RD_CFG_SECOND) ||
                    (c == hvip_pkg::HVIP_RD_STATUS) || (c == hvip_pkg::HVIP_RD_MONITOR) ||
                    (c == hvip_pkg::HVIP_WR_CFG_FIRST) || (c == hvip_pkg::HVIP_WR_CFG_SECOND);
    endfunction

    // ---------------- APB side (pclk) ----------------
    logic [31:0] prdata_q; // Read data captured in setup
    logic pready_q; // High during the single access cycle
    logic pslverr_q; // Error for unmapped addresses
    logic busy_q; // Transfer in flight
    logic tx_ok_q; // Send outcome
    logic rx_ok_q; // Read-back outcome
    logic [11:0] data_q; // Data port: tag in 11:8, byte in 7:0
    logic req_tgl_q; // Start event toggle toward the link
    logic done_s1_q, done_s2_q, done_s3_q; // Done toggle synchroniser
    logic done_tgl_q; // Completion toggle toward pclk, driven in the link domain
    logic done_evt; // One pulse per finished transfer
    logic setup_ph; // APB setup cycle
    logic wr_acc; // Write takes effect this edge
    logic hit_cmd, hit_data; // Address decode
    logic cmd_go; // Accepted command write
    hvip_pkg::hvip_result_t res_q; // Link result, stable outside transfers

    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign hit_cmd = (paddr == hvip_pkg::HVIP_CMD_ADDR);
    assign hit_data = (paddr == hvip_pkg::HVIP_DATA_ADDR);
    assign cmd_go = wr_acc & hit_cmd & pstrb[0] & ~busy_q & cmd_valid(pwdata[7:0]);
    assign done_evt = done_s2_q ^ done_s3_q;

    // Bus answer: zero wait states, so the master sees pready in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (setup_ph) begin
            pready_q <= 1'b1;
            pslverr_q <= ~(hit_cmd | hit_data);
            if (hit_cmd) begin
                // Upper bits reserved, read as zero
                prdata_q <= {29'h00000000, tx_ok_q, rx_ok_q, busy_q};
            end else if (hit_data) begin
                prdata_q <= {20'h00000, data_q};
            end else begin
                prdata_q <= 32'h00000000;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Busy flag: raised by an accepted command, lowered when the result is in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= hvip_pkg::HVIP_CMD_RESET[hvip_pkg::HVIP_BUSY_BIT];
        end else if (cmd_go) begin
            busy_q <= 1'b1;
        end else if (done_evt) begin
            busy_q <= 1'b0;
        end
    end

    // Outcome flags change only at completion, so they are frozen while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ok_q <= hvip_pkg::HVIP_CMD_RESET[hvip_pkg::HVIP_TXOK_BIT];
            rx_ok_q <= hvip_pkg::HVIP_CMD_RESET[hvip_pkg::HVIP_RXOK_BIT];
        end else if (done_evt) begin
            tx_ok_q <= res_q.ack;
            rx_ok_q <= res_q.rd_ok & ~data_q[8 + hvip_pkg::HVIP_WRITE_CMD_BIT];
        end
    end

    // Data port: software byte, command tag, read-back byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= hvip_pkg::HVIP_DATA_RESET;
        end else if (cmd_go) begin
            data_q[11:8] <= pwdata[3:0];
        end else if (done_evt && !data_q[8 + hvip_pkg::HVIP_WRITE_CMD_BIT] && res_q.rd_ok) begin
            data_q[7:0] <= res_q.rd_val;
        end else if (wr_acc && hit_data && pstrb[0] && !busy_q) begin
            // Byte is frozen while busy so the link reads a stable word
            data_q[7:0] <= pwdata[7:0];
        end
    end

    // Start event toggle: frame word is held stable by busy until done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_tgl_q <= 1'b0;
        end else if (cmd_go) begin
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // Done toggle crossing from the link domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else begin
            done_s1_q <= done_tgl_q;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- Link side (hv_link_clk) ----------------
    logic lrst_s1_q, lrst_n_q; // Reset released in the link domain
    logic req_s1_q, req_s2_q, req_s3_q; // Start toggle synchroniser
    logic start_evt; // One pulse per new command
    hvip_pkg::hvip_state_t st_q; // Link sequencer
    logic ph_q; // Half-bit phase: 0 low, 1 high
    logic [3:0] cnt_q; // Bits left in current field
    logic [11:0] sh_q; // Outgoing shift register
    logic [8:0] rx_q; // Incoming byte plus parity
    logic sclk_q, sdo_q, soe_q; // Pin drivers
    logic sdi_s1_q, sdi_s2_q; // Far-end data line synchroniser
    logic ack_slot; // Edge at which the synchronised acknowledge is judged
    logic bit_end; // Last half of a bit
    hvip_pkg::hvip_frame_t frame; // Word the link sends

    assign frame = hvip_pkg::hvip_frame_t'(data_q);
    assign start_evt = req_s2_q ^ req_s3_q;
    assign bit_end = ph_q;
    // First low half after the acknowledge bit: the synchroniser now holds that bit
    assign ack_slot = (st_q == hvip_pkg::HVIP_RECV) && !ph_q && (cnt_q == (hvip_pkg::HVIP_RESP_LAST + 4'h1));

    // Reset synchroniser: asynchronous assert, release on the link clock
    always_ff @(posedge hv_link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_s1_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_n_q <= lrst_s1_q;
        end
    end

    // Far-end data line: two flip-flops before any logic reads it
    // The cost is one link clock of lag, so each bit is judged on the edge after it ends
    always_ff @(posedge hv_link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
        end else begin
            sdi_s1_q <= hv_sdata_in;
            sdi_s2_q <= sdi_s1_q;
        end
    end

    // Start toggle crossing from the APB domain
    always_ff @(posedge hv_link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // Sequencer: serial clock high in the second half of each bit
    always_ff @(posedge hv_link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            st_q <= hvip_pkg::HVIP_IDLE;
            ph_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 12'h000;
            rx_q <= 9'h000;
            sclk_q <= 1'b0;
            sdo_q <= 1'b0;
            soe_q <= 1'b0;
        end else begin
            case (st_q)
                hvip_pkg::HVIP_IDLE: begin
                    sclk_q <= 1'b0;
                    ph_q <= 1'b0;
                    if (start_evt) begin
                        // Tag then byte, most significant bit first
                        st_q <= hvip_pkg::HVIP_SEND;
                        sdo_q <= frame.tag[3];
                        sh_q <= {frame.tag[2:0], frame.val, 1'b0};
                        soe_q <= 1'b1;
                        cnt_q <= hvip_pkg::HVIP_FRAME_LAST;
                    end
                end
                hvip_pkg::HVIP_SEND: begin
                    ph_q <= ~ph_q;
                    sclk_q <= ~ph_q;
                    if (bit_end) begin
                        if (cnt_q == 4'h0) begin
                            st_q <= hvip_pkg::HVIP_TURN;
                            soe_q <= 1'b0; // Hand the line over
                            sdo_q <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                            sdo_q <= sh_q[11];
                            sh_q <= {sh_q[10:0], 1'b0};
                        end
                    end
                end
                hvip_pkg::HVIP_TURN: begin
                    ph_q <= ~ph_q;
                    sclk_q <= ~ph_q;
                    if (bit_end) begin
                        st_q <= hvip_pkg::HVIP_ACK;
                    end
                end
                hvip_pkg::HVIP_ACK: begin
                    ph_q <= ~ph_q;
                    sclk_q <= ~ph_q;
                    if (bit_end) begin
                        // Acknowledge is judged one link clock later, once it has crossed
                        st_q <= hvip_pkg::HVIP_RECV;
                        cnt_q <= hvip_pkg::HVIP_RESP_LAST + 4'h1;
                    end
                end
                hvip_pkg::HVIP_RECV: begin
                    ph_q <= ~ph_q;
                    sclk_q <= ~ph_q;
                    if (ack_slot) begin
                        // Reads continue only after an acknowledge; writes end here
                        if (!sdi_s2_q || frame.tag[hvip_pkg::HVIP_WRITE_CMD_BIT]) begin
                            st_q <= hvip_pkg::HVIP_DONE;
                            sclk_q <= 1'b0;
                            ph_q <= 1'b0;
                        end else begin
                            cnt_q <= hvip_pkg::HVIP_RESP_LAST;
                        end
                    end else if (!ph_q) begin
                        // Synchroniser holds the bit that ended on the previous edge
                        rx_q <= {rx_q[7:0], sdi_s2_q};
                        if (cnt_q == 4'h0) begin
                            // No further clock rise once the parity bit is in
                            st_q <= hvip_pkg::HVIP_DONE;
                            sclk_q <= 1'b0;
                            ph_q <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                end
                hvip_pkg::HVIP_DONE: begin
                    sclk_q <= 1'b0;
                    ph_q <= 1'b0;
                    st_q <= hvip_pkg::HVIP_IDLE;
                end
                default: begin
                    st_q <= hvip_pkg::HVIP_IDLE;
                    soe_q <= 1'b0;
                end
            endcase
        end
    end

    // Result capture; held until the next start so pclk reads it safely
    always_ff @(posedge hv_link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            res_q <= '0;
        end else if (start_evt) begin
            res_q <= '0;
        end else if (ack_slot) begin
            res_q.ack <= sdi_s2_q;
        end else if (st_q == hvip_pkg::HVIP_DONE) begin
            res_q.rd_ok <= res_q.ack & ^rx_q;
            res_q.rd_val <= rx_q[8:1];
        end
    end

    // Completion toggle, on the same link clock edge that stores the result
    always_ff @(posedge hv_link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            done_tgl_q <= 1'b0;
        end else if (st_q == hvip_pkg::HVIP_DONE) begin
            done_tgl_q <= ~done_tgl_q;
        end
    end

    assign hv_sclk = sclk_q;
    assign hv_sdata_out = sdo_q;
    assign hv_sdata_oe = soe_q;

    // ---------------- Checks ----------------
    int unsigned busy_cnt_q; // Cycles spent busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_q ? busy_cnt_q + 1 : 0;
        end
    end

    chk_busy_rise: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go |=> busy_q) else $error("busy did not rise after command");
    chk_busy_bound: assert property (@(posedge pclk) disable iff (!presetn)
        busy_cnt_q <= hvip_pkg::HVIP_LATENCY_CYC) else $error("transfer exceeded latency");
    chk_busy_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && hit_cmd) |=> prdata_q[0] == $past(busy_q)) else $error("busy bit misread");
    chk_cmd_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && hit_cmd) |=> prdata_q[31:3] == 29'h00000000) else $error("reserved bits set");
    chk_data_width: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && hit_data) |=> prdata_q[31:12] == 20'h00000) else $error("data port too wide");
    chk_tag_load: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go |=> data_q[11:8] == $past(pwdata[3:0])) else $error("command tag not stored");
    chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !done_evt |=> $stable({tx_ok_q, rx_ok_q})) else $error("flags moved while busy");
    chk_read_load: assert property (@(posedge pclk) disable iff (!presetn)
        (done_evt && res_q.rd_ok && !data_q[11]) |=> data_q[7:0] == $past(res_q.rd_val))
        else $error("read data not loaded");
    chk_write_norx: assert property (@(posedge pclk) disable iff (!presetn)
        (done_evt && data_q[11]) |=> !rx_ok_q) else $error("read flag set on write");
    chk_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !hit_cmd && !hit_data) |=> pslverr_q && pready_q) else $error("unmapped not refused");
    chk_link_idle: assert property (@(posedge hv_link_clk) disable iff (!lrst_n_q)
        (st_q == hvip_pkg::HVIP_IDLE) |-> (!soe_q && !sclk_q)) else $error("link active while idle");
    chk_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_q && !done_evt) |=> busy_q) else $error("busy dropped before completion");
    chk_line_released: assert property (@(posedge hv_link_clk) disable iff (!lrst_n_q)
        (st_q != hvip_pkg::HVIP_IDLE && st_q != hvip_pkg::HVIP_SEND) |-> !soe_q)
        else $error("data line driven outside send");
    chk_sclk_toggle: assert property (@(posedge hv_link_clk) disable iff (!lrst_n_q)
        (st_q == hvip_pkg::HVIP_SEND && $past(st_q) == hvip_pkg::HVIP_SEND) |-> (sclk_q != $past(sclk_q)))
        else $error("serial clock stalled while sending");

endmodule // hvip_port

`default_nettype wire

/* File: hvip_far_model.sv */
// Behavioural model of the high-voltage register set at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none

module hvip_far_model #(
    parameter logic [7:0] STATUS_VAL = 8'h5C,  // Status contents, arbitrary test value
    parameter logic [7:0] MONITOR_VAL = 8'h3A  // Monitor contents, arbitrary test value
) (
    input wire logic hv_sclk,
    input wire logic hv_sdata_out,
    input wire logic hv_sdata_oe,
    input wire logic ack_en,
    input wire logic parity_bad,
    output logic sdata_far,
    output logic [7:0] cfg_first_q,
    output logic [7:0] cfg_second_q
);
    logic [4:0] bit_q;   // Serial clock rises seen in this frame
    logic [11:0] rx_q;   // Tag and byte shifted in from the device
    logic [8:0] tx_q;    // Reply byte plus parity
    logic rd_q;          // Frame is a read that earns a reply

    initial begin
        bit_q = 5'h00;
        rx_q = 12'h000;
        tx_q = 9'h000;
        rd_q = 1'b0;
        sdata_far = 1'b0;
        cfg_first_q = 8'h00;
        cfg_second_q = 8'h00;
    end

    // Device raises its enable only at the first bit, so that marks a new frame
    always @(posedge hv_sdata_oe) begin
        bit_q = 5'h00;
    end

    // Capture device bits MSB first on the rising serial clock
    always @(posedge hv_sclk) begin
        if (bit_q < 5'h0C) begin
            rx_q = {rx_q[10:0], hv_sdata_out};
        end
        bit_q = bit_q + 5'h01;
        if (bit_q == 5'h0C) begin
            rd_q = ack_en && (rx_q[11:8] < 4'h4);
            if (ack_en && rx_q[11:8] == 4'h8) begin
                cfg_first_q = rx_q[7:0];
            end
            if (ack_en && rx_q[11:8] == 4'h9) begin
                cfg_second_q = rx_q[7:0];
            end
            case (rx_q[9:8])
                2'h0: tx_q[8:1] = cfg_first_q;
                2'h1: tx_q[8:1] = cfg_second_q;
                2'h2: tx_q[8:1] = STATUS_VAL;
                default: tx_q[8:1] = MONITOR_VAL;
            endcase
            // Odd parity, inverted on purpose when the bench asks for a corrupt reply
            tx_q[0] = ~^tx_q[8:1] ^ parity_bad;
        end
    end

    // Change the line at the start of each bit; when released it shows a toggling pattern
    always @(negedge hv_sclk) begin
        if (bit_q == 5'h0D) begin
            sdata_far <= ack_en;
        end else if (rd_q && bit_q >= 5'h0E && bit_q <= 5'h16) begin
            sdata_far <= tx_q[8];
            tx_q = {tx_q[7:0], 1'b0};
        end else begin
            sdata_far <= ~sdata_far;
        end
    end
endmodule // hvip_far_model

`default_nettype wire

/* File: hv_indirect_register_port_tb_top.sv */
// Self-checking testbench for the high-voltage indirect register port
`timescale 1ns/1ps
`default_nettype none

module hv_indirect_register_port_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lclk = 1'b0;
    logic sclk, sdo, soe, sfar, ack_en = 1'b1, par_bad = 1'b0;
    logic [7:0] cfg0, cfg1;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int check_count = 0;
    localparam logic [7:0] ST = 8'h5C;  // Must match the model's status value
    localparam logic [7:0] MN = 8'h3A;  // Must match the model's monitor value

    // Core clock, 20 ns
    always #10 pclk = ~pclk;
    // Link clock, 160 ns, offset so its edges never line up with the core clock
    initial begin
        #3;
        forever begin
            lclk = ~lclk;
            #80;
        end
    end

    hvip_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hv_link_clk(lclk), .hv_sdata_in(soe ? sdo : sfar), .hv_sclk(sclk), .hv_sdata_out(sdo),
        .hv_sdata_oe(soe));
    hvip_far_model #(.STATUS_VAL(ST), .MONITOR_VAL(MN)) far (.hv_sclk(sclk), .hv_sdata_out(sdo),
        .hv_sdata_oe(soe), .ack_en(ack_en), .parity_bad(par_bad), .sdata_far(sfar),
        .cfg_first_q(cfg0), .cfg_second_q(cfg1));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; pready, prdata and pslverr are taken at the rising edge that ends the access
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Issue a command, optionally meddle while busy, wait for completion and judge the flags
    task automatic do_cmd(input logic [7:0] cmd, input logic [1:0] fl, input logic cd,
                          input logic [11:0] dat, input logic meddle);
        time t0;
        apb(1'b1, hvip_pkg::HVIP_CMD_ADDR, {24'h000000, cmd});
        t0 = $time;
        apb(1'b0, hvip_pkg::HVIP_CMD_ADDR, 32'h00000000);
        chk({31'h0, rd[0]}, 32'h1);
        if (meddle) begin
            // Both writes must be dropped while the link is busy
            apb(1'b1, hvip_pkg::HVIP_CMD_ADDR, 32'h00000009);
            apb(1'b1, hvip_pkg::HVIP_DATA_ADDR, 32'h000000FF);
            apb(1'b0, hvip_pkg::HVIP_CMD_ADDR, 32'h00000000);
            chk({31'h0, rd[0]}, 32'h1);
        end
        for (int n = 0; n < 400 && rd[0] !== 1'b0; n++) begin
            apb(1'b0, hvip_pkg::HVIP_CMD_ADDR, 32'h00000000);
        end
        chk({31'h0, ($time - t0) <= 64'd10000}, 32'h1);
        chk(rd, {29'h0, fl, 1'b0});
        if (cd) begin
            apb(1'b0, hvip_pkg::HVIP_DATA_ADDR, 32'h00000000);
            chk(rd, {20'h00000, dat});
        end
    endtask

    // Reset state and the unmapped address
    task automatic t_reset;
        apb(1'b0, hvip_pkg::HVIP_CMD_ADDR, 32'h00000000);
        chk(rd, 32'h00000000);
        apb(1'b0, hvip_pkg::HVIP_DATA_ADDR, 32'h00000000);
        chk(rd, 32'h00000000);
        apb(1'b0, 32'hFFFF0808, 32'h00000000);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
    endtask

    // Both write codes, then every read code
    task automatic t_codes;
        apb(1'b1, hvip_pkg::HVIP_DATA_ADDR, 32'h000000A5);
        do_cmd(hvip_pkg::HVIP_WR_CFG_FIRST, 2'b10, 1'b0, 12'h000, 1'b0);
        chk({24'h0, cfg0}, 32'h000000A5);
        apb(1'b1, hvip_pkg::HVIP_DATA_ADDR, 32'h0000003C);
        do_cmd(hvip_pkg::HVIP_WR_CFG_SECOND, 2'b10, 1'b0, 12'h000, 1'b0);
        chk({24'h0, cfg1}, 32'h0000003C);
        do_cmd(hvip_pkg::HVIP_RD_CFG_FIRST, 2'b11, 1'b1, 12'h0A5, 1'b0);
        do_cmd(hvip_pkg::HVIP_RD_CFG_SECOND, 2'b11, 1'b1, 12'h13C, 1'b0);
        do_cmd(hvip_pkg::HVIP_RD_STATUS, 2'b11, 1'b1, {4'h2, ST}, 1'b0);
        do_cmd(hvip_pkg::HVIP_RD_MONITOR, 2'b11, 1'b1, {4'h3, MN}, 1'b0);
        $display("test codes done");
    endtask

    // Writes during busy, corrupt parity, refused ack and a reserved code
    task automatic t_faults;
        do_cmd(hvip_pkg::HVIP_RD_STATUS, 2'b11, 1'b1, {4'h2, ST}, 1'b1);
        chk({24'h0, cfg1}, 32'h0000003C);
        par_bad <= 1'b1;
        do_cmd(hvip_pkg::HVIP_RD_MONITOR, 2'b10, 1'b1, {4'h3, ST}, 1'b0);
        par_bad <= 1'b0;
        ack_en <= 1'b0;
        do_cmd(hvip_pkg::HVIP_WR_CFG_FIRST, 2'b00, 1'b0, 12'h000, 1'b0);
        ack_en <= 1'b1;
        chk({24'h0, cfg0}, 32'h000000A5);
        apb(1'b1, hvip_pkg::HVIP_CMD_ADDR, 32'h00000005);
        apb(1'b0, hvip_pkg::HVIP_CMD_ADDR, 32'h00000000);
        chk(rd, 32'h00000000);
        $display("test faults done");
    endtask

    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: reset, let the link leave reset, then the tests
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        t_reset();
        t_codes();
        t_faults();
        results();
    end

    // Watchdog well beyond nine commands of 500 cycles each
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        results();
    end
endmodule // hv_indirect_register_port_tb_top

`default_nettype wire
